// ### hw/cwd_decoder.sv
`timescale 1ns/100ps
module cwd_decoder (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // non-volatile storage image
   input wire logic [13:0] i_nv_word_one,
   input wire logic [13:0] i_nv_word_two,
   // programmer side
   input wire logic i_prog_active,
   input wire logic i_prog_entry_lv,
   input wire logic i_prog_write,
   input wire logic [15:0] i_prog_addr,
   input wire logic [13:0] i_prog_data,
   input wire logic i_prog_bulk_erase,
   input wire logic i_prog_end,
   // self-write check
   input wire logic [10:0] i_self_write_addr,
   // register port
   input wire logic [1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   output logic [31:0] o_reg_rdata,
   // decoded settings, storage write-back and erase strobes
   output cwd_pkg::cwd_cfg_s o_cfg,
   output logic o_lv_entry_allowed,
   output logic o_self_write_blocked,
   output logic [13:0] o_nv_word_one,
   output logic [13:0] o_nv_word_two,
   output logic o_nv_store,
   output logic o_erase_program,
   output logic o_erase_data
);
   // ************************************************************
   // latched words and programmer write path
   // ************************************************************
   logic [13:0] w1_q;
   logic [13:0] w2_q;
   logic [13:0] pend1_q;
   logic [13:0] pend2_q;
   logic lv_session_q;
   logic load_q;
   logic [13:0] w2_masked;
   logic hit_one;
   logic hit_two;
   logic [13:0] new_two;

   assign hit_one = i_prog_active && i_prog_write &&
                    (i_prog_addr == cwd_pkg::CFG_ADDR_ONE);
   assign hit_two = i_prog_active && i_prog_write &&
                    (i_prog_addr == cwd_pkg::CFG_ADDR_TWO);

   // a session opened by low voltage keeps the enable bit at one
   always_comb begin
      new_two = i_prog_data | cwd_pkg::W2_FORCED_ONES;
      if (lv_session_q) begin
         new_two[cwd_pkg::W2_LVP] = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lv_session_q <= 1'b0;
      end else if (i_ce) begin
         if (!i_prog_active || i_prog_end) begin
            lv_session_q <= 1'b0;
         end else if (i_prog_entry_lv) begin
            lv_session_q <= 1'b1;
         end
      end
   end

   // reload from storage one edge after reset release
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         load_q <= 1'b1;
      end else if (i_ce) begin
         load_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pend1_q <= cwd_pkg::CFG_ERASED;
         pend2_q <= cwd_pkg::CFG_ERASED;
      end else if (i_ce) begin
         if (load_q) begin
            pend1_q <= i_nv_word_one;
            pend2_q <= i_nv_word_two | cwd_pkg::W2_FORCED_ONES;
         end else if (i_prog_active && i_prog_bulk_erase) begin
            pend1_q <= cwd_pkg::CFG_ERASED;
            pend2_q <= cwd_pkg::CFG_ERASED;
         end else begin
            if (hit_one) begin
               pend1_q <= i_prog_data;
            end
            if (hit_two) begin
               pend2_q <= new_two;
            end
         end
      end
   end

   // decoded words change only at load or session end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         w1_q <= cwd_pkg::CFG_ERASED;
         w2_q <= cwd_pkg::CFG_ERASED;
      end else if (i_ce) begin
         if (load_q) begin
            w1_q <= i_nv_word_one;
            w2_q <= i_nv_word_two | cwd_pkg::W2_FORCED_ONES;
         end else if (i_prog_active && i_prog_end) begin
            w1_q <= pend1_q;
            w2_q <= pend2_q;
         end
      end
   end

   assign w2_masked = w2_q | cwd_pkg::W2_FORCED_ONES;

   // ************************************************************
   // erase side effects
   // ************************************************************
   logic cp_off_going;
   logic cpd_off_going;
   assign cp_off_going = hit_one && !pend1_q[cwd_pkg::W1_CP] &&
                         i_prog_data[cwd_pkg::W1_CP];
   assign cpd_off_going = !pend1_q[cwd_pkg::W1_CPD] &&
                          i_prog_bulk_erase && i_prog_active;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_erase_program <= 1'b0;
         o_erase_data <= 1'b0;
         o_nv_store <= 1'b0;
         o_nv_word_one <= cwd_pkg::CFG_ERASED;
         o_nv_word_two <= cwd_pkg::CFG_ERASED;
      end else if (i_ce) begin
         // protection cleared wipes program memory
         o_erase_program <= cp_off_going;
         o_erase_data <= cpd_off_going;
         o_nv_store <= i_prog_active && i_prog_end;
         if (i_prog_active && i_prog_end) begin
            o_nv_word_one <= pend1_q;
            o_nv_word_two <= pend2_q;
         end
      end
   end

   // ************************************************************
   // field decode
   // ************************************************************
   cwd_pkg::cwd_osc_e osc;
   logic crystal;
   logic [1:0] self_write_protect_range;
   assign osc = cwd_pkg::cwd_osc_e'(w1_q[cwd_pkg::W1_OSC_LO +: 3]);
   assign self_write_protect_range = w2_masked[cwd_pkg::W2_WRT_LO +: 2];

   always_comb begin
      case (osc)
         cwd_pkg::OSC_LP_XTAL, cwd_pkg::OSC_XT_XTAL,
         cwd_pkg::OSC_HS_XTAL: begin
            crystal = 1'b1;
         end
         default: begin
            crystal = 1'b0;
         end
      endcase
   end

   always_comb begin
      o_cfg = '0;
      o_cfg.failsafe_monitor_enable = w1_q[cwd_pkg::W1_FCM];
      o_cfg.two_speed_switchover_enable = w1_q[cwd_pkg::W1_TWO_SPEED_SWITCHOVER_ENABLE];
      o_cfg.osc_pin_is_crystal = crystal;
      o_cfg.clock_output_enable = !crystal &&
                                  !w1_q[cwd_pkg::W1_CLKO];
      o_cfg.brownout_reset_mode =
         cwd_pkg::cwd_mode_e'(w1_q[cwd_pkg::W1_BOR_LO +: 2]);
      o_cfg.data_protect = !w1_q[cwd_pkg::W1_CPD];
      o_cfg.program_protect = !w1_q[cwd_pkg::W1_CP];
      o_cfg.reset_pin_is_reset = w2_masked[cwd_pkg::W2_LVP] ||
                                 w1_q[cwd_pkg::W1_RSTPIN];
      o_cfg.reset_pin_pullup_forced = o_cfg.reset_pin_is_reset;
      o_cfg.powerup_timer_enable = !w1_q[cwd_pkg::W1_POWERUP_TIMER];
      o_cfg.watchdog_mode =
         cwd_pkg::cwd_mode_e'(w1_q[cwd_pkg::W1_WDT_LO +: 2]);
      o_cfg.oscillator_select = osc;
      o_cfg.clock_input_pin_is_io = (osc == cwd_pkg::OSC_INTERNAL);
      o_cfg.low_voltage_program_enable = w2_masked[cwd_pkg::W2_LVP];
      o_cfg.debugger_enable = !w2_masked[cwd_pkg::W2_DBG];
      o_cfg.brownout_level_low = w2_masked[cwd_pkg::W2_BROWNOUT_LEVEL_SELECT];
      o_cfg.stack_fault_reset_enable = w2_masked[cwd_pkg::W2_STACK];
      o_cfg.times_four_multiplier_enable = w2_masked[cwd_pkg::W2_PLL];
      case (self_write_protect_range)
         2'h3: begin
            o_cfg.write_protect_any = 1'b0;
            o_cfg.write_protect_limit = '0;
         end
         2'h2: begin
            o_cfg.write_protect_any = 1'b1;
            o_cfg.write_protect_limit = cwd_pkg::WRT_LIM_HALF;
         end
         2'h1: begin
            o_cfg.write_protect_any = 1'b1;
            o_cfg.write_protect_limit = cwd_pkg::WRT_LIM_MOST;
         end
         default: begin
            o_cfg.write_protect_any = 1'b1;
            o_cfg.write_protect_limit = cwd_pkg::WRT_LIM_ALL;
         end
      endcase
   end

   assign o_lv_entry_allowed = w2_masked[cwd_pkg::W2_LVP];
   assign o_self_write_blocked = o_cfg.write_protect_any &&
      (i_self_write_addr <= o_cfg.write_protect_limit);

   // ************************************************************
   // register port, read only; writes are ignored
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h0;
      end else if (i_ce) begin
         o_reg_rdata <= 32'h0;
         if (i_reg_read) begin
            case (i_reg_addr)
               cwd_pkg::REG_WORD_ONE: begin
                  o_reg_rdata <= {18'h0, w1_q};
               end
               cwd_pkg::REG_WORD_TWO: begin
                  o_reg_rdata <= {18'h0, w2_masked};
               end
               cwd_pkg::REG_STATUS: begin
                  o_reg_rdata <= {29'h0, lv_session_q, i_prog_active,
                                  load_q};
               end
               default: begin
                  o_reg_rdata <= 32'h0;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_fcm_follow: assert property (@(posedge i_clk) disable iff (i_rst)
      o_cfg.failsafe_monitor_enable == w1_q[13])
      else $error("fail-safe enable mismatch");
   chk_clock_output_pin_crystal: assert property (@(posedge i_clk) disable iff (i_rst)
      (w1_q[2:0] <= 3'h2) |-> !o_cfg.clock_output_enable)
      else $error("clock out driven in crystal mode");
   chk_bor_powerup_timer_indep: assert property (@(posedge i_clk)
      disable iff (i_rst)
      o_cfg.powerup_timer_enable == !w1_q[5])
      else $error("power-up timer follows brown-out");
   chk_rst_pin_lvp: assert property (@(posedge i_clk) disable iff (i_rst)
      w2_masked[13] |-> o_cfg.reset_pin_is_reset)
      else $error("reset pin select not ignored");
   chk_lvp_keep: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && lv_session_q && hit_two && !load_q &&
       !i_prog_bulk_erase) |=> pend2_q[13])
      else $error("enable bit cleared in low-voltage session");
   chk_hold_stable: assert property (@(posedge i_clk) disable iff (i_rst)
      (!$past(load_q) && !($past(i_prog_active) && $past(i_prog_end)))
      |-> $stable(w1_q))
      else $error("word changed mid session");
   chk_cp_erase: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && cp_off_going) |=> o_erase_program)
      else $error("program erase missing");
   chk_wrt_block: assert property (@(posedge i_clk) disable iff (i_rst)
      (self_write_protect_range == 2'h2 && i_self_write_addr == 11'h200)
      |-> !o_self_write_blocked)
      else $error("write above limit blocked");
   chk_unimpl_ones: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_reg_read && i_reg_addr == 2'h1)
      |=> (o_reg_rdata[11] && o_reg_rdata[7:2] == 6'h3F))
      else $error("unimplemented bits not one");
endmodule

// ### shared/cwd_pkg.sv
package cwd_pkg;
   // ************************************************************
   // configuration memory addresses and word layout
   // ************************************************************
   localparam logic [15:0] CFG_ADDR_ONE = 16'h8007;
   localparam logic [15:0] CFG_ADDR_TWO = 16'h8008;
   localparam int CFG_W = 14;
   localparam logic [13:0] CFG_ERASED = 14'h3FFF;
   // word two bits that are not implemented or reserved read as one
   localparam logic [13:0] W2_FORCED_ONES = 14'h08FC;
   // word one fields
   localparam int W1_FCM = 13;
   localparam int W1_TWO_SPEED_SWITCHOVER_ENABLE = 12;
   localparam int W1_CLKO = 11;
   localparam int W1_BOR_LO = 9;
   localparam int W1_CPD = 8;
   localparam int W1_CP = 7;
   localparam int W1_RSTPIN = 6;
   localparam int W1_POWERUP_TIMER = 5;
   localparam int W1_WDT_LO = 3;
   localparam int W1_OSC_LO = 0;
   // word two fields
   localparam int W2_LVP = 13;
   localparam int W2_DBG = 12;
   localparam int W2_BROWNOUT_LEVEL_SELECT = 10;
   localparam int W2_STACK = 9;
   localparam int W2_PLL = 8;
   localparam int W2_WRT_LO = 0;
   // register port offsets
   localparam logic [1:0] REG_WORD_ONE = 2'h0;
   localparam logic [1:0] REG_WORD_TWO = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   // self-write protect upper limits
   localparam logic [10:0] WRT_LIM_HALF = 11'h1FF;
   localparam logic [10:0] WRT_LIM_MOST = 11'h3FF;
   localparam logic [10:0] WRT_LIM_ALL = 11'h7FF;

   typedef enum logic [2:0] {
      OSC_LP_XTAL, OSC_XT_XTAL, OSC_HS_XTAL, OSC_EXT_RC,
      OSC_INTERNAL, OSC_EC_LOW, OSC_EC_MED, OSC_EC_HIGH
   } cwd_osc_e;

   typedef enum logic [1:0] {
      MODE_OFF, MODE_SOFTWARE, MODE_RUN_ONLY, MODE_ALWAYS
   } cwd_mode_e;

   typedef struct packed {
      logic failsafe_monitor_enable;
      logic two_speed_switchover_enable;
      logic clock_output_enable;
      logic osc_pin_is_crystal;
      cwd_mode_e brownout_reset_mode;
      logic data_protect;
      logic program_protect;
      logic reset_pin_is_reset;
      logic reset_pin_pullup_forced;
      logic powerup_timer_enable;
      cwd_mode_e watchdog_mode;
      cwd_osc_e oscillator_select;
      logic clock_input_pin_is_io;
      logic low_voltage_program_enable;
      logic debugger_enable;
      logic brownout_level_low;
      logic stack_fault_reset_enable;
      logic times_four_multiplier_enable;
      logic [10:0] write_protect_limit;
      logic write_protect_any;
   } cwd_cfg_s;
endpackage

// ### verification/cwd_programmer.sv
`timescale 1ns/100ps
module cwd_programmer (
   input wire logic i_clk,
   output logic o_active,
   output logic o_entry_lv,
   output logic o_write,
   output logic [15:0] o_addr,
   output logic [13:0] o_data,
   output logic o_erase,
   output logic o_end
);
   initial begin
      o_active = 1'b0;
      o_entry_lv = 1'b0;
      o_write = 1'b0;
      o_addr = 16'h0000;
      o_data = 14'h0000;
      o_erase = 1'b0;
      o_end = 1'b0;
   end
   task automatic open_session(input logic lv);
      @(posedge i_clk);
      o_active <= 1'b1;
      o_entry_lv <= lv;
   endtask
   task automatic put_word(input logic [15:0] a, input logic [13:0] d);
      @(posedge i_clk);
      o_write <= 1'b1;
      o_addr <= a;
      // reserved bit of word two always goes out high
      o_data <= (a == cwd_pkg::CFG_ADDR_TWO) ? (d | 14'h0010) : d;
      @(posedge i_clk);
      o_write <= 1'b0;
      // released lines flip so a stale value never looks valid
      o_addr <= ~a;
      o_data <= ~d;
   endtask
   task automatic erase_all();
      @(posedge i_clk);
      o_erase <= 1'b1;
      @(posedge i_clk);
      o_erase <= 1'b0;
   endtask
   task automatic close_session();
      @(posedge i_clk);
      o_end <= 1'b1;
      @(posedge i_clk);
      o_end <= 1'b0;
      o_active <= 1'b0;
      o_entry_lv <= 1'b0;
   endtask
endmodule

// ### verification/cwd_decoder_bench.sv
`timescale 1ns/100ps
module cwd_decoder_bench;
   typedef struct {
      logic [13:0] w1;
      logic [13:0] w2;
      cwd_pkg::cwd_osc_e osc;
      cwd_pkg::cwd_mode_e bor;
      cwd_pkg::cwd_mode_e wdt;
      logic [10:0] lim;
   } cwd_row_s;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [13:0] nv1 = 14'h0000;
   logic [13:0] nv2 = 14'h0000;
   logic [10:0] self_addr = 11'h000;
   logic [1:0] reg_addr = 2'h0;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic ce = 1'b1;
   logic p_act, p_lv, p_wr, p_er, p_end;
   logic [15:0] p_addr;
   logic [13:0] p_data;
   logic [31:0] rdata;
   cwd_pkg::cwd_cfg_s cfg;
   logic lv_ok, blocked, store, ep, ed;
   logic [13:0] nvo1, nvo2;
   int error_cnt = 0;
   int n_compared = 0;
   int n_ep = 0;
   int n_ed = 0;
   int n_st = 0;
   logic [31:0] v;
   cwd_row_s row_tab [8] = '{
      '{14'h39F8, 14'h2AFC, cwd_pkg::OSC_LP_XTAL, cwd_pkg::MODE_OFF,
        cwd_pkg::MODE_ALWAYS, 11'h7FF},
      '{14'h0211, 14'h2CFD, cwd_pkg::OSC_XT_XTAL, cwd_pkg::MODE_SOFTWARE,
        cwd_pkg::MODE_RUN_ONLY, 11'h3FF},
      '{14'h3DEA, 14'h3AFE, cwd_pkg::OSC_HS_XTAL, cwd_pkg::MODE_RUN_ONLY,
        cwd_pkg::MODE_SOFTWARE, 11'h1FF},
      '{14'h0603, 14'h3CFF, cwd_pkg::OSC_EXT_RC, cwd_pkg::MODE_ALWAYS,
        cwd_pkg::MODE_OFF, 11'h000},
      '{14'h39FC, 14'h0BFC, cwd_pkg::OSC_INTERNAL, cwd_pkg::MODE_OFF,
        cwd_pkg::MODE_ALWAYS, 11'h7FF},
      '{14'h0215, 14'h0DFD, cwd_pkg::OSC_EC_LOW, cwd_pkg::MODE_SOFTWARE,
        cwd_pkg::MODE_RUN_ONLY, 11'h3FF},
      '{14'h3DEE, 14'h1BFE, cwd_pkg::OSC_EC_MED, cwd_pkg::MODE_RUN_ONLY,
        cwd_pkg::MODE_SOFTWARE, 11'h1FF},
      '{14'h0607, 14'h1DFF, cwd_pkg::OSC_EC_HIGH, cwd_pkg::MODE_ALWAYS,
        cwd_pkg::MODE_OFF, 11'h000}};

   always #50 i_clk = ~i_clk;

   cwd_programmer u_prog (.i_clk(i_clk), .o_active(p_act), .o_entry_lv(p_lv),
      .o_write(p_wr), .o_addr(p_addr), .o_data(p_data), .o_erase(p_er),
      .o_end(p_end));

   cwd_decoder uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
      .i_nv_word_one(nv1), .i_nv_word_two(nv2), .i_prog_active(p_act),
      .i_prog_entry_lv(p_lv), .i_prog_write(p_wr), .i_prog_addr(p_addr),
      .i_prog_data(p_data), .i_prog_bulk_erase(p_er), .i_prog_end(p_end),
      .i_self_write_addr(self_addr), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_write(reg_write),
      .i_reg_read(reg_read), .o_reg_rdata(rdata), .o_cfg(cfg),
      .o_lv_entry_allowed(lv_ok), .o_self_write_blocked(blocked),
      .o_nv_word_one(nvo1), .o_nv_word_two(nvo2), .o_nv_store(store),
      .o_erase_program(ep), .o_erase_data(ed));

   // ************************************************************
   // pulse counters: a pulse that stands two cycles counts twice
   // ************************************************************
   always @(posedge i_clk) begin
      if (ep === 1'b1) n_ep++;
      if (ed === 1'b1) n_ed++;
      if (store === 1'b1) n_st++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge i_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge i_clk);
      reg_read <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic sw(input logic [10:0] a, input logic e);
      @(posedge i_clk);
      self_addr <= a;
      @(posedge i_clk);
      #1;
      chk(blocked, e);
   endtask

   task automatic reload(input logic [13:0] w1, input logic [13:0] w2);
      @(posedge i_clk);
      i_rst <= 1'b1;
      nv1 <= w1;
      nv2 <= w2;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
   endtask

   task automatic check_row(input cwd_row_s r);
      logic x;
      x = (r.w1[2:0] < 3'h3);
      chk(cfg.failsafe_monitor_enable, r.w1[13]);
      chk(cfg.two_speed_switchover_enable, r.w1[12]);
      chk(cfg.osc_pin_is_crystal, x);
      chk(cfg.clock_output_enable, !x && !r.w1[11]);
      chk(cfg.brownout_reset_mode, r.bor);
      chk(cfg.data_protect, !r.w1[8]);
      chk(cfg.program_protect, !r.w1[7]);
      if (!r.w2[13]) begin
         chk(cfg.reset_pin_is_reset, r.w1[6]);
         chk(cfg.reset_pin_pullup_forced, r.w1[6]);
      end
      chk(cfg.powerup_timer_enable, !r.w1[5]);
      chk(cfg.watchdog_mode, r.wdt);
      chk(cfg.oscillator_select, r.osc);
      chk(cfg.clock_input_pin_is_io, r.w1[2:0] == 3'h4);
      chk(cfg.low_voltage_program_enable, r.w2[13]);
      chk(lv_ok, r.w2[13]);
      chk(cfg.debugger_enable, !r.w2[12]);
      chk(cfg.brownout_level_low, r.w2[10]);
      chk(cfg.stack_fault_reset_enable, r.w2[9]);
      chk(cfg.times_four_multiplier_enable, r.w2[8]);
      chk(cfg.write_protect_any, r.w2[1:0] != 2'h3);
      sw(r.lim, r.w2[1:0] != 2'h3);
      if (r.lim != 11'h7FF) sw(r.lim + 11'h001, 1'b0);
      rd(2'h0, v);
      chk(v, {18'h0, r.w1});
      rd(2'h1, v);
      chk(v, {18'h0, r.w2 | 14'h08FC});
      rd(2'h3, v);
      chk(v, 32'h0);
   endtask

   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #(100 * 3000);
      error_cnt++;
      $display("ERROR at %0t: watchdog expired", $time);
      finish_test();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge i_clk);
      #1;
      chk(cfg.watchdog_mode, cwd_pkg::MODE_ALWAYS);
      chk(rdata, 32'h0);
      $display("reset test done");
      foreach (row_tab[k]) begin
         reload(row_tab[k].w1, row_tab[k].w2);
         check_row(row_tab[k]);
         $display("row %0d done", k);
      end
      // storage changes and register writes must not move live settings
      @(posedge i_clk);
      nv1 <= 14'h3FFF;
      reg_wdata <= 32'hFFFFFFFF;
      reg_write <= 1'b1;
      @(posedge i_clk);
      reg_write <= 1'b0;
      rd(2'h0, v);
      chk(v, 32'h0607);
      $display("hold test done");
      u_prog.open_session(1'b0);
      u_prog.put_word(16'h8006, 14'h0000);
      u_prog.put_word(cwd_pkg::CFG_ADDR_ONE, 14'h0687);
      repeat (3) @(posedge i_clk);
      chk(n_ep, 1);
      chk(cfg.program_protect, 1'b1);
      u_prog.close_session();
      repeat (3) @(posedge i_clk);
      chk(n_st, 1);
      chk(cfg.program_protect, 1'b0);
      chk(nvo1, 14'h0687);
      chk(nvo2, 14'h1DFF);
      $display("program test done");
      u_prog.open_session(1'b0);
      u_prog.erase_all();
      repeat (3) @(posedge i_clk);
      chk(n_ed, 1);
      u_prog.close_session();
      rd(2'h0, v);
      chk(v, 32'h3FFF);
      rd(2'h1, v);
      chk(v, 32'h3FFF);
      $display("erase test done");
      u_prog.open_session(1'b1);
      u_prog.put_word(cwd_pkg::CFG_ADDR_TWO, 14'h0000);
      u_prog.close_session();
      repeat (3) @(posedge i_clk);
      chk(cfg.low_voltage_program_enable, 1'b1);
      chk(cfg.debugger_enable, 1'b1);
      chk(cfg.write_protect_any, 1'b1);
      $display("low-voltage test done");
      // a frozen block must not answer a read
      @(posedge i_clk);
      ce <= 1'b0;
      reg_addr <= 2'h1;
      reg_read <= 1'b1;
      @(posedge i_clk);
      reg_read <= 1'b0;
      ce <= 1'b1;
      #1;
      chk(rdata, 32'h0);
      $display("clock enable test done");
      finish_test();
   end
endmodule
